/* hw/usb_dev_pkg.sv */
// Overview of operation
// - Sleep sets sleep flag, clears wake, idles pad
// - Bus activity sets wake, clears sleep, wakes pad
// - Disabled controller or disconnect forces pad idle
// - Pad reactivates on enable one, disconnect zero
// - Status bit 14 shows generic clock usable
// - Speed field 00 full, 10 low
// - Name word at 0x824 is read-only
// - Enable bit one lets its source interrupt
// - Clear register ones clear matching enables
// - Set register ones set matching enables
// - Enable bits 0,2,3,4,5,6 per source
// - Endpoint enables from bit 12 upward
package usb_dev_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int EP_NUM = 7;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_DEV_CTRL    = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_FLAGS       = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_FLAGS_CLR   = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN      = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN_CLR  = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN_SET  = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_GEN_CTRL    = 12'h800;
    localparam logic [ADDR_W-1:0] OFS_GEN_STATUS  = 12'h804;
    localparam logic [ADDR_W-1:0] OFS_IP_LABEL    = 12'h824;

    // Interrupt source bit positions
    localparam int SLEEP_BIT      = 0;
    localparam int FRAME_BIT      = 2;
    localparam int RST_END_BIT    = 3;
    localparam int ACTIVITY_BIT   = 4;
    localparam int RSM_END_BIT    = 5;
    localparam int UP_RSM_BIT     = 6;
    localparam int EP_LSB         = 12;

    // Control and status field positions
    localparam int DISCONNECT_BIT = 8;
    localparam int CTRL_EN_BIT    = 15;
    localparam int GCLK_OK_BIT    = 14;
    localparam int SPEED_LSB      = 12;

    localparam logic [1:0] SPEED_FULL = 2'h0;
    localparam logic [1:0] SPEED_LOW  = 2'h2;

    // Implemented interrupt bits
    localparam logic [DATA_W-1:0] IRQ_MASK = 32'h0007f07d;
    localparam logic [DATA_W-1:0] RST_ZERO = 32'h00000000;
    localparam logic              DISC_RST = 1'b1;

    // Name word, arbitrary value
    localparam logic [DATA_W-1:0] IP_LABEL = 32'h55534244;

    // Pad state, one-hot
    typedef enum logic [1:0] {
        PAD_IDLE   = 2'b01,
        PAD_ACTIVE = 2'b10
    } pad_state_t;
    localparam int PAD_ACTIVE_IDX = 1;

    // Register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    // Same-clock bus event pulses
    typedef struct packed {
        logic              frame_start;
        logic              reset_end;
        logic              resume_end;
        logic              upstream_resume;
        logic [EP_NUM-1:0] endpoint;
    } link_evt_t;

    // Asynchronous bus pin levels
    typedef struct packed {
        logic bus_sleep;
        logic bus_activity;
        logic gclk_usable;
        logic low_speed;
    } pin_lvl_t;

endpackage : usb_dev_pkg

/* hw/usb_device_pad_irq_status.sv */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps

// Three-stage synchroniser, change accepted when stages two and three agree
module pin_sync3 #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] level
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;

    // Synchroniser chain
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept per bit when the later stages agree
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            level_q <= '0;
        end
        else
        begin
            for (int i = 0; i < W; i++)
            begin
                if (s2_q[i] == s3_q[i])
                begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign level = level_q;

endmodule : pin_sync3

// Device pad control, status bits and global interrupt enables
module usb_device_pad_irq_status (
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    input  wire usb_dev_pkg::reg_req_t   req,
    output logic [usb_dev_pkg::DATA_W-1:0] rdata,
    input  wire usb_dev_pkg::pin_lvl_t   pins,
    input  wire usb_dev_pkg::link_evt_t  evt,
    output logic                         pad_active,
    output logic                         irq
);
    import usb_dev_pkg::*;

    pin_lvl_t          pin_s;
    pin_lvl_t          pin_prev_q;
    logic              sleep_evt;
    logic              activity_evt;

    logic              ctrl_en_q;
    logic              disconnect_q;
    logic              ctrl_wr;
    pad_state_t        pad_q;
    logic              en_next;
    logic              disc_next;

    logic [DATA_W-1:0] flags_q;
    logic [DATA_W-1:0] flags_d;
    logic [DATA_W-1:0] flag_set;
    logic [DATA_W-1:0] flag_clr;
    logic [DATA_W-1:0] irq_en_q;
    logic [DATA_W-1:0] status_q;
    logic [DATA_W-1:0] rdata_q;
    logic              irq_q;

    logic              wr_dev_ctrl;
    logic              wr_gen_ctrl;
    logic              wr_flags_clr;
    logic              wr_en_clr;
    logic              wr_en_set;

    // Pin levels into the core clock
    pin_sync3 #(
        .W($bits(pin_lvl_t))
    ) u_pin_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .din      (pins),
        .level    (pin_s)
    );

    // Previous accepted levels for edge detection
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_prev_q <= '0;
        end
        else
        begin
            pin_prev_q <= pin_s;
        end
    end

    // Rising edges of sleep and activity detections
    assign sleep_evt    = pin_s.bus_sleep & ~pin_prev_q.bus_sleep;
    assign activity_evt = pin_s.bus_activity
                        & ~pin_prev_q.bus_activity;

    // Write strobe decode
    assign wr_dev_ctrl  = req.wr && (req.addr == OFS_DEV_CTRL);
    assign wr_gen_ctrl  = req.wr && (req.addr == OFS_GEN_CTRL);
    assign wr_flags_clr = req.wr && (req.addr == OFS_FLAGS_CLR);
    assign wr_en_clr    = req.wr && (req.addr == OFS_IRQ_EN_CLR);
    assign wr_en_set    = req.wr && (req.addr == OFS_IRQ_EN_SET);
    assign ctrl_wr      = wr_dev_ctrl | wr_gen_ctrl;

    // Control values as they stand after this edge, so a write acts at once
    assign en_next      = wr_gen_ctrl ? req.wdata[CTRL_EN_BIT] : ctrl_en_q;
    assign disc_next    = wr_dev_ctrl ? req.wdata[DISCONNECT_BIT]
                                      : disconnect_q;

    // Disconnect control bit, set out of reset
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            disconnect_q <= DISC_RST;
        end
        else if (wr_dev_ctrl)
        begin
            disconnect_q <= req.wdata[DISCONNECT_BIT];
        end
    end

    // Controller enable bit
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_en_q <= 1'b0;
        end
        else if (wr_gen_ctrl)
        begin
            ctrl_en_q <= req.wdata[CTRL_EN_BIT];
        end
    end

    // Pad state machine
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pad_q <= PAD_IDLE;
        end
        else
        begin
            case (pad_q)
                PAD_IDLE:
                begin
                    if (en_next && !disc_next
                        && (activity_evt || ctrl_wr))
                    begin
                        pad_q <= PAD_ACTIVE;
                    end
                end
                PAD_ACTIVE:
                begin
                    if (!en_next || disc_next)
                    begin
                        pad_q <= PAD_IDLE;
                    end
                    else if (sleep_evt && !activity_evt)
                    begin
                        pad_q <= PAD_IDLE;
                    end
                end
                default:
                begin
                    pad_q <= PAD_IDLE;
                end
            endcase
        end
    end

    assign pad_active = pad_q[PAD_ACTIVE_IDX];

    // Flag sources; activity beats sleep on a tie
    always_comb
    begin
        flag_set = '0;
        flag_clr = '0;
        if (wr_flags_clr)
        begin
            flag_clr = req.wdata & IRQ_MASK;
        end
        if (activity_evt)
        begin
            flag_set[ACTIVITY_BIT] = 1'b1;
            flag_clr[SLEEP_BIT]    = 1'b1;
        end
        else if (sleep_evt)
        begin
            flag_set[SLEEP_BIT]    = 1'b1;
            flag_clr[ACTIVITY_BIT] = 1'b1;
        end
        flag_set[FRAME_BIT]   = evt.frame_start;
        flag_set[RST_END_BIT] = evt.reset_end;
        flag_set[RSM_END_BIT] = evt.resume_end;
        flag_set[UP_RSM_BIT]  = evt.upstream_resume;
        flag_set[EP_LSB +: EP_NUM] = evt.endpoint;
    end

    // Hardware set wins over any clear
    assign flags_d = ((flags_q & ~flag_clr) | flag_set) & IRQ_MASK;

    // Sticky interrupt flags
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            flags_q <= RST_ZERO;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    // Enable register with set and clear companions
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_en_q <= RST_ZERO;
        end
        else if (wr_en_set)
        begin
            irq_en_q <= irq_en_q | (req.wdata & IRQ_MASK);
        end
        else if (wr_en_clr)
        begin
            irq_en_q <= irq_en_q & ~req.wdata;
        end
    end

    // Interrupt line from enabled flags
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(flags_d & irq_en_q);
        end
    end

    assign irq = irq_q;

    // General status snapshot
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            status_q <= RST_ZERO;
        end
        else
        begin
            status_q <= RST_ZERO;
            status_q[GCLK_OK_BIT] <= pin_s.gclk_usable;
            status_q[SPEED_LSB +: 2] <= pin_s.low_speed
                                      ? SPEED_LOW
                                      : SPEED_FULL;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_q <= RST_ZERO;
        end
        else if (req.rd)
        begin
            case (req.addr)
                OFS_DEV_CTRL:
                begin
                    rdata_q <= RST_ZERO;
                    rdata_q[DISCONNECT_BIT] <= disconnect_q;
                end
                OFS_GEN_CTRL:
                begin
                    rdata_q <= RST_ZERO;
                    rdata_q[CTRL_EN_BIT] <= ctrl_en_q;
                end
                OFS_FLAGS:      rdata_q <= flags_q;
                OFS_IRQ_EN:     rdata_q <= irq_en_q;
                OFS_GEN_STATUS: rdata_q <= status_q;
                OFS_IP_LABEL:   rdata_q <= IP_LABEL;
                default:        rdata_q <= RST_ZERO;
            endcase
        end
        else
        begin
            rdata_q <= RST_ZERO;
        end
    end

    assign rdata = rdata_q;

endmodule : usb_device_pad_irq_status

/* dv/usb_pad_irq_properties.sv */
`timescale 1ns/1ps

// Port-level checks of pad, status and enables
module usb_pad_irq_properties (
    input wire logic                           core_clk,
    input wire logic                           nrst,
    input wire usb_dev_pkg::reg_req_t          req,
    input wire logic [usb_dev_pkg::DATA_W-1:0] rdata,
    input wire usb_dev_pkg::pin_lvl_t          pins,
    input wire usb_dev_pkg::link_evt_t         evt,
    input wire logic                           pad_active,
    input wire logic                           irq
);
    import usb_dev_pkg::*;

    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // Register reads
    a_label_read: assert property (
        $past(req.rd) && $past(req.addr) == OFS_IP_LABEL
        |-> rdata == IP_LABEL)
        else $error("name word read wrong");
    a_speed_code: assert property (
        $past(req.rd) && $past(req.addr) == OFS_GEN_STATUS
        |-> !rdata[SPEED_LSB])
        else $error("reserved speed code");
    a_enable_set: assert property (
        req.wr && req.addr == OFS_IRQ_EN_SET
        ##1 req.rd && req.addr == OFS_IRQ_EN
        |=> (~rdata & $past(req.wdata, 2) & IRQ_MASK) == 32'h0)
        else $error("enable set lost");
    a_enable_clr: assert property (
        req.wr && req.addr == OFS_IRQ_EN_CLR
        ##1 req.rd && req.addr == OFS_IRQ_EN
        |=> (rdata & $past(req.wdata, 2)) == 32'h0)
        else $error("enable clear lost");
    // Interrupt and pad
    a_irq_masked: assert property (
        req.wr && req.addr == OFS_IRQ_EN_CLR && (&req.wdata)
        ##1 !req.wr |=> !irq)
        else $error("irq with all enables clear");
    a_pad_cut: assert property (
        req.wr && (req.addr == OFS_DEV_CTRL && req.wdata[DISCONNECT_BIT]
        || req.addr == OFS_GEN_CTRL && !req.wdata[CTRL_EN_BIT])
        |-> ##[1:2] !pad_active)
        else $error("pad not idled by control");
    a_sleep_idle: assert property (
        $rose(pins.bus_sleep) |-> ##[4:6] !pad_active)
        else $error("pad not idled by sleep");
    a_wake_pad: assert property (
        $rose(pins.bus_activity) |-> ##[4:6] pad_active)
        else $error("pad not woken by activity");
endmodule : usb_pad_irq_properties

bind usb_device_pad_irq_status usb_pad_irq_properties chk (
    .core_clk, .nrst, .req, .rdata, .pins, .evt, .pad_active, .irq);

/* dv/usb_host_model.sv */
`timescale 1ns/1ps

// Host line states at the pins; sleep and traffic exclusive
module usb_host_model (
    input  wire logic                  core_clk,
    input  wire usb_dev_pkg::pin_lvl_t want,
    output usb_dev_pkg::pin_lvl_t      pins
);
    import usb_dev_pkg::*;

    // Line changes land on the clock edge
    always_ff @(posedge core_clk)
    begin
        pins.bus_sleep    <= want.bus_sleep & ~want.bus_activity;
        pins.bus_activity <= want.bus_activity;
        pins.gclk_usable  <= want.gclk_usable;
        pins.low_speed    <= want.low_speed;
    end
endmodule : usb_host_model

/* dv/test_usb_device_pad_irq_status.sv */
`timescale 1ns/1ps

module test_usb_device_pad_irq_status;
    import usb_dev_pkg::*;

    logic        core_clk;
    logic        nrst;
    reg_req_t    req;
    logic [31:0] rdata;
    pin_lvl_t    want;
    pin_lvl_t    pins;
    link_evt_t   evt;
    logic        pad_active;
    logic        irq;
    logic [31:0] seed;
    logic [31:0] em;
    logic [31:0] r;
    int          n_fail;
    int          checks_done;
    int          i;

    usb_device_pad_irq_status uut (.core_clk(core_clk), .nrst(nrst),
        .req(req), .rdata(rdata), .pins(pins), .evt(evt),
        .pad_active(pad_active), .irq(irq));
    usb_host_model host (.core_clk(core_clk), .want(want), .pins(pins));

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Implemented enables: sources, then one per endpoint
    function automatic logic [31:0] en_bits();
        return 32'h7d | (((32'h1 << EP_NUM) - 1) << EP_LSB);
    endfunction : en_bits

    function automatic logic [31:0] evt_flags(input link_evt_t e);
        return {13'h0, e.endpoint, 5'h0, e.upstream_resume, e.resume_end,
                1'b0, e.reset_end, e.frame_start, 2'h0};
    endfunction : evt_flags

    task automatic bus(input logic w, input logic rd, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        req <= '{w, rd, a, d};
    endtask : bus

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rd_chk(input string nm, input logic [11:0] a,
                          input logic [31:0] e);
        bus(1'b0, 1'b1, a, 32'h0);
        bus(1'b0, 1'b0, 12'h0, 32'h0);
        #1 chk(nm, e, rdata);
    endtask : rd_chk

    // Write, let the effect land, then look at the pad and irq
    task automatic wr_look(input logic [11:0] a, input logic [31:0] d,
                           input logic p, input logic q);
        bus(1'b1, 1'b0, a, d);
        repeat (3) bus(1'b0, 1'b0, 12'h0, 32'h0);
        #1 chk("pad_active", {31'h0, p}, {31'h0, pad_active});
        chk("irq", {31'h0, q}, {31'h0, irq});
    endtask : wr_look

    task automatic rst(input int n);
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (n) @(posedge core_clk);
        nrst <= 1'b1;
        rd_chk("enable_reset", OFS_IRQ_EN, 32'h0);
        rd_chk("disconnect_reset", OFS_DEV_CTRL, 32'h100);
        chk("pad_reset", 32'h0, {31'h0, pad_active});
    endtask : rst

    task automatic tally_and_finish();
        if (n_fail == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #20000;
        n_fail++;
        tally_and_finish();
    end

    initial
    begin
        nrst = 1'b0;
        req = '0;
        evt = '0;
        want = '0;
        want.gclk_usable = 1'b1;
        seed = 32'd5242;
        em = 32'h0;
        n_fail = 0;
        checks_done = 0;
        rst(10);
        rd_chk("label", OFS_IP_LABEL, IP_LABEL);
        bus(1'b1, 1'b0, OFS_IP_LABEL, xs());
        rd_chk("label_after_write", OFS_IP_LABEL, IP_LABEL);
        // Set and clear back to back with readback
        for (i = 0; i < 24; i++)
        begin
            r = (i < 2) ? 32'hffffffff : xs();
            em = i[0] ? (em & ~r) : (em | (r & en_bits()));
            bus(1'b1, 1'b0, i[0] ? OFS_IRQ_EN_CLR : OFS_IRQ_EN_SET, r);
            rd_chk("enables", OFS_IRQ_EN, em);
        end
        for (i = 0; i < 4; i++)
        begin
            want.gclk_usable <= i[0];
            want.low_speed <= i[1];
            repeat (6) bus(1'b0, 1'b0, 12'h0, 32'h0);
            rd_chk("status", OFS_GEN_STATUS, {17'h0, i[0], i[1], 13'h0});
        end
        wr_look(OFS_IRQ_EN_CLR, 32'hffffffff, 1'b0, 1'b0);
        wr_look(OFS_GEN_CTRL, 32'h8000, 1'b0, 1'b0);
        wr_look(OFS_DEV_CTRL, 32'h0, 1'b1, 1'b0);
        wr_look(OFS_DEV_CTRL, 32'h100, 1'b0, 1'b0);
        wr_look(OFS_DEV_CTRL, 32'h0, 1'b1, 1'b0);
        wr_look(OFS_GEN_CTRL, 32'h0, 1'b0, 1'b0);
        wr_look(OFS_GEN_CTRL, 32'h8000, 1'b1, 1'b0);
        rd_chk("ctrl_enable", OFS_GEN_CTRL, 32'h8000);
        want.bus_sleep <= 1'b1;
        // Host flop plus pin synchroniser before the edge is seen
        repeat (4) bus(1'b0, 1'b0, 12'h0, 32'h0);
        wr_look(OFS_IRQ_EN_SET, 32'h1, 1'b0, 1'b1);
        rd_chk("flags_sleep", OFS_FLAGS, 32'h1);
        wr_look(OFS_IRQ_EN_CLR, 32'hffffffff, 1'b0, 1'b0);
        want.bus_sleep <= 1'b0;
        want.bus_activity <= 1'b1;
        repeat (4) bus(1'b0, 1'b0, 12'h0, 32'h0);
        wr_look(OFS_IRQ_EN_SET, 32'h0, 1'b1, 1'b0);
        rd_chk("flags_wake", OFS_FLAGS, 32'h10);
        wr_look(OFS_IRQ_EN_SET, 32'h10, 1'b1, 1'b1);
        wr_look(OFS_FLAGS_CLR, 32'hffffffff, 1'b1, 1'b0);
        for (i = 0; i < 6; i++)
        begin
            r = xs();
            @(posedge core_clk);
            evt <= link_evt_t'(r[10:0]);
            @(posedge core_clk);
            evt <= '0;
            rd_chk("flags_evt", OFS_FLAGS, evt_flags(link_evt_t'(r[10:0])));
            bus(1'b1, 1'b0, OFS_FLAGS_CLR, 32'hffffffff);
            bus(1'b0, 1'b0, 12'h0, 32'h0);
        end
        want.bus_activity <= 1'b0;
        rst(3);
        tally_and_finish();
    end
endmodule : test_usb_device_pad_irq_status
